// ---- tit_top.sv ----
// Function
// RULE_01: three presettable 16-bit down-counters, load values 2 to 65535 by mode.
// RULE_02: each counter divides its input clock by the loaded value.
// RULE_03: counter 0 runs at 10 MHz and drives the tick output.
// RULE_04: gate of counters 1 and 2 is bit 1 at 10h; high stops, resets low.
// RULE_05: counters 1 and 2 form a 32-bit divider at 2 MHz driving conversion trigger.
// RULE_06: counter 1 output clocks counter 2; both share the software gate.
// RULE_07: mode 0 output low after load, high at zero, counts while gate allows.
// RULE_08: mode 1 output low after gate rise, high at zero; retriggers reload.
// RULE_09: mode 2 pulses low one clock every N counts, reloads, stops on gate low.
// RULE_10: mode 3 square wave, decrement by two; odd N gives longer high half.
// RULE_11: mode 4 high output, counts from load, one low pulse at zero, no repeat.
// RULE_12: mode 5 counts after gate rise, low pulse at terminal count, retriggerable.
// RULE_13: counter data ports at 14h to 16h, write-only control word at 17h.
// RULE_14: control bits 7:6 pick counter 0, 1, 2, or 3 for readback.
// RULE_15: control bits 5:4 pick latch, low only, high only, low then high.
// RULE_16: control bits 3:1 pick mode; bit 3 ignored for modes 2 and 3.
// RULE_17: control bit 0 selects binary when clear, decimal counting when set.
// RULE_18: latch copies live count to hold register; reads return held value.
// RULE_19: two-byte order alternates bytes by toggle; host keeps accesses paired.
// RULE_20: readback latches counts and or status on all picked counters at once.
// RULE_21: status byte holds output, null count, order, mode and decimal bit.
// RULE_22: status plus count latch in two-byte order reads status, low, high.
// RULE_23: further latches ignored until hold read; latched status reads first.
`timescale 1ns/1ps
`include "tit_defines.svh"

module tit_top import tit_pkg::*; (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // byte i/o port, one-cycle strobes from logic on clk
    input  wire logic [4:0] io_addr,
    input  wire logic       io_wr_en,
    input  wire logic       io_rd_en,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // board outputs
    output logic            tick_out,
    output logic            conv_trig_out
);

    // decimal-aware decrement by one; a zero count wraps to the top value
    function automatic logic [15:0] tit_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (b) begin
                    if (r[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                        b = 1'b0;
                    end
                end
            end
        end
        return r; // see RULE_17
    endfunction
    // fold the don't-care top bit for modes 2 and 3
    function automatic tit_mode_e tit_eff_mode(input logic [2:0] m);
        if (m[1]) begin
            return tit_mode_e'({1'b0, m[1:0]}); // see RULE_16
        end
        return tit_mode_e'(m);
    endfunction
    // fractional rate step: returns {enable, next accumulator}
    function automatic logic [8:0] tit_frac(input logic [7:0] acc, input logic [7:0] f);
        logic [8:0] s;
        s = {1'b0, acc} + {1'b0, f};
        if (s >= {1'b0, `TIT_CLK_MHZ}) begin
            return {1'b1, s[7:0] - `TIT_CLK_MHZ};
        end
        return {1'b0, s[7:0]};
    endfunction
    // rate enables; 125 is no multiple of 10, so the 10 MHz enable jitters
    // by one system clock but keeps the exact average rate
    logic [7:0] acc10_r;
    logic [7:0] acc2_r;
    logic       en10_r;
    logic       en2_r;
    wire  [8:0] frac10_w = tit_frac(acc10_r, `TIT_F0_MHZ);
    wire  [8:0] frac2_w  = tit_frac(acc2_r, `TIT_F12_MHZ);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc10_r <= 8'h00;
            acc2_r  <= 8'h00;
            en10_r  <= 1'b0;
            en2_r   <= 1'b0;
        end else begin
            acc10_r <= frac10_w[7:0];
            acc2_r  <= frac2_w[7:0];
            en10_r  <= frac10_w[8]; // see RULE_03
            en2_r   <= frac2_w[8];  // see RULE_05
        end
    end
    // address decode of the i/o port
    wire       hit_gate_w = (io_addr == `TIT_OFF_GATE_CTRL);
    wire       hit_cw_w   = (io_addr == `TIT_OFF_CTRL_WORD);
    wire [2:0] hit_cnt_w  = {io_addr == `TIT_OFF_CNT2,
                             io_addr == `TIT_OFF_CNT1,
                             io_addr == `TIT_OFF_CNT0}; // see RULE_13
    // control word decode
    wire       cw_wr_w  = io_wr_en && hit_cw_w;
    wire [1:0] cw_sel_w = io_wdata[`TIT_CW_SEL_MSB:`TIT_CW_SEL_LSB]; // see RULE_14
    wire       cw_rb_w  = cw_wr_w && (cw_sel_w == `TIT_CW_SEL_RB)
                          && !io_wdata[`TIT_CW_BCD_BIT]; // see RULE_20
    wire [1:0] cw_ord_w = io_wdata[`TIT_CW_ORD_MSB:`TIT_CW_ORD_LSB]; // see RULE_15
    wire [2:0] rb_pick_w = io_wdata[`TIT_RB_PICK_LSB +: 3];
    // gate register; software sets the bit to stop counters 1 and 2
    logic gate_off_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_off_r <= `TIT_GATE_OFF_RST;
        end else if (io_wr_en && hit_gate_w) begin
            gate_off_r <= io_wdata[`TIT_GATE_BIT]; // see RULE_04
        end
    end

    // counter clocks and gates; counter 2 steps on each rising edge of counter 1
    logic       out1_d_r;
    wire  [2:0] out_w;
    wire  [2:0] ce_w   = {out_w[1] && !out1_d_r, en2_r, en10_r}; // see RULE_06
    wire  [2:0] gate_w = {!gate_off_r, !gate_off_r, 1'b1};        // see RULE_06
    wire  [7:0] rd_byte_w [3];

    // three identical counters
    for (genvar i = 0; i < 3; i++) begin : g_cnt
        logic [15:0] cnt_r;    // counting element
        logic [15:0] cr_r;     // last written count
        logic [15:0] lat_r;    // hold register
        logic [7:0]  st_r;     // latched status
        logic [2:0]  mode_r;
        tit_order_e  ord_r;
        logic        bcd_r, out_r, null_r;
        logic        pend_r;   // written count waits for the counting element
        logic        wrote_r;  // some count has been written since programming
        logic        run_r, gate_d_r, wtog_r, rtog_r, lat_v_r, st_v_r;
        // per-counter decode
        wire        sel_w   = (cw_sel_w == 2'(i));
        wire        prog_w  = cw_wr_w && sel_w && (cw_ord_w != TIT_ORD_LATCH);
        wire        clat_w  = (cw_wr_w && sel_w && (cw_ord_w == TIT_ORD_LATCH))
                              || (cw_rb_w && rb_pick_w[i]
                                  && !io_wdata[`TIT_RB_CNT_N_BIT]); // see RULE_20
        wire        slat_w  = cw_rb_w && rb_pick_w[i]
                              && !io_wdata[`TIT_RB_STA_N_BIT];       // see RULE_20
        wire        wr_w    = io_wr_en && hit_cnt_w[i];
        wire        rd_w    = io_rd_en && hit_cnt_w[i];
        wire        done_w  = wr_w && (ord_r != TIT_ORD_BOTH || wtog_r);
        wire        ce      = ce_w[i];
        wire        gate    = gate_w[i];
        wire        trig_w  = ce && gate && !gate_d_r && wrote_r;
        tit_mode_e  eff_w;
        wire [15:0] dec1_w  = tit_dec(cnt_r, bcd_r);
        wire [15:0] dec2_w  = tit_dec(dec1_w, bcd_r);
        wire [15:0] src_w   = lat_v_r ? lat_r : cnt_r; // see RULE_18
        wire        hi_w    = (ord_r == TIT_ORD_MSB)
                              || (ord_r == TIT_ORD_BOTH && rtog_r); // see RULE_19

        assign eff_w        = tit_eff_mode(mode_r);
        assign out_w[i]     = out_r;
        // status byte comes first when latched
        assign rd_byte_w[i] = st_v_r ? st_r : (hi_w ? src_w[15:8] : src_w[7:0]); // see RULE_23

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                cnt_r    <= 16'h0000;
                cr_r     <= 16'h0000;
                lat_r    <= 16'h0000;
                st_r     <= 8'h00;
                mode_r   <= 3'h0;
                ord_r    <= TIT_ORD_LSB;
                bcd_r    <= 1'b0;
                out_r    <= 1'b1;
                null_r   <= 1'b1;
                pend_r   <= 1'b0;
                wrote_r  <= 1'b0;
                run_r    <= 1'b0;
                gate_d_r <= 1'b0;
                wtog_r   <= 1'b0;
                rtog_r   <= 1'b0;
                lat_v_r  <= 1'b0;
                st_v_r   <= 1'b0;
            end else if (prog_w) begin
                // programming stops the counter until a new count arrives
                mode_r  <= io_wdata[`TIT_CW_MODE_MSB:`TIT_CW_MODE_LSB];
                bcd_r   <= io_wdata[`TIT_CW_BCD_BIT]; // see RULE_17
                ord_r   <= tit_order_e'(cw_ord_w);
                out_r   <= (tit_eff_mode(io_wdata[3:1]) != TIT_MODE_0);
                null_r  <= 1'b1;
                pend_r  <= 1'b0;
                wrote_r <= 1'b0;
                run_r   <= 1'b0;
                wtog_r  <= 1'b0;
                rtog_r  <= 1'b0;
                lat_v_r <= 1'b0;
                st_v_r  <= 1'b0;
            end else begin
                // counting, one step per input clock enable
                if (ce) begin
                    gate_d_r <= gate;
                    case (eff_w)
                        TIT_MODE_0: begin
                            if (pend_r) begin
                                cnt_r  <= cr_r;
                                pend_r <= 1'b0;
                                null_r <= 1'b0;
                                run_r  <= 1'b1;
                                out_r  <= 1'b0;
                            end else if (run_r && gate) begin
                                cnt_r <= dec1_w;
                                if (dec1_w == 16'h0000) out_r <= 1'b1; // see RULE_07
                            end
                        end
                        TIT_MODE_1, TIT_MODE_5: begin
                            if (trig_w) begin
                                cnt_r  <= cr_r; // see RULE_08
                                pend_r <= 1'b0;
                                null_r <= 1'b0;
                                run_r  <= 1'b1;
                                out_r  <= (eff_w == TIT_MODE_5);
                            end else if (eff_w == TIT_MODE_5 && !out_r) begin
                                out_r <= 1'b1; // see RULE_12
                            end else if (run_r) begin
                                cnt_r <= dec1_w;
                                if (dec1_w == 16'h0000) begin
                                    out_r <= (eff_w == TIT_MODE_1); // see RULE_12
                                    run_r <= 1'b0;
                                end
                            end
                        end
                        TIT_MODE_4: begin
                            if (pend_r) begin
                                cnt_r  <= cr_r;
                                pend_r <= 1'b0;
                                null_r <= 1'b0;
                                run_r  <= 1'b1;
                                out_r  <= 1'b1;
                            end else if (!out_r) begin
                                out_r <= 1'b1; // one input period low only
                            end else if (run_r && gate) begin
                                cnt_r <= dec1_w;
                                if (dec1_w == 16'h0000) begin
                                    out_r <= 1'b0; // see RULE_11
                                    run_r <= 1'b0;
                                end
                            end
                        end
                        TIT_MODE_2: begin
                            if (!gate) begin
                                out_r <= 1'b1; // see RULE_09
                            end else if ((pend_r && !run_r) || trig_w || (run_r
                                         && cnt_r == 16'h0001)) begin
                                cnt_r  <= cr_r; // see RULE_09
                                pend_r <= 1'b0;
                                null_r <= 1'b0;
                                run_r  <= 1'b1;
                                out_r  <= 1'b1;
                            end else if (run_r) begin
                                cnt_r <= dec1_w; // see RULE_02
                                out_r <= (dec1_w != 16'h0001);
                            end
                        end
                        TIT_MODE_3: begin
                            if (!gate) begin
                                out_r <= 1'b1;
                            end else if ((pend_r && !run_r) || trig_w) begin
                                cnt_r  <= cr_r;
                                pend_r <= 1'b0;
                                null_r <= 1'b0;
                                run_r  <= 1'b1;
                                out_r  <= 1'b1;
                            end else if (run_r && (cnt_r == 16'h0001
                                         || cnt_r == 16'h0002)) begin
                                // odd count: high half from N, low half from N-1
                                out_r  <= !out_r; // see RULE_10
                                cnt_r  <= out_r ? {cr_r[15:1], 1'b0} : cr_r;
                                pend_r <= 1'b0;
                                null_r <= 1'b0;
                            end else if (run_r) begin
                                cnt_r <= dec2_w; // see RULE_10
                            end
                        end
                        default: begin
                            run_r <= 1'b0;
                        end
                    endcase
                end
                // count writes come last so a write never loses to a reload
                if (wr_w) begin
                    case (ord_r)
                        TIT_ORD_MSB: cr_r[15:8] <= io_wdata;
                        TIT_ORD_BOTH: begin
                            if (wtog_r) begin
                                cr_r[15:8] <= io_wdata;
                            end else begin
                                cr_r[7:0] <= io_wdata;
                            end
                            wtog_r <= !wtog_r; // see RULE_19
                        end
                        default: cr_r <= {8'h00, io_wdata}; // see RULE_01
                    endcase
                    if (ord_r == TIT_ORD_MSB) cr_r[7:0] <= 8'h00;
                end
                if (done_w) begin
                    pend_r  <= 1'b1;
                    wrote_r <= 1'b1;
                    null_r  <= 1'b1; // see RULE_21
                    if (eff_w == TIT_MODE_0) begin
                        out_r <= 1'b0; // see RULE_07
                        run_r <= 1'b0;
                    end
                end
                // latch commands are ignored while a hold is unread
                if (clat_w && !lat_v_r) begin
                    lat_r   <= cnt_r; // see RULE_18
                    lat_v_r <= 1'b1;  // see RULE_23
                end
                if (slat_w && !st_v_r) begin
                    st_r   <= {out_r, null_r, ord_r, mode_r, bcd_r}; // see RULE_21
                    st_v_r <= 1'b1;
                end
                // reads consume status first, then the count bytes
                if (rd_w) begin
                    if (st_v_r) begin
                        st_v_r <= 1'b0; // see RULE_22
                    end else if (ord_r == TIT_ORD_BOTH && !rtog_r) begin
                        rtog_r <= 1'b1; // see RULE_19
                    end else begin
                        rtog_r  <= 1'b0;
                        lat_v_r <= 1'b0; // see RULE_22
                    end
                end
            end
        end
    end

    // read data mux; the control word reads as zero
    wire [7:0] rd_mux_w = hit_cnt_w[0] ? rd_byte_w[0] :
                          hit_cnt_w[1] ? rd_byte_w[1] :
                          hit_cnt_w[2] ? rd_byte_w[2] :
                          hit_gate_w   ? {6'h00, gate_off_r, 1'b0} : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            io_rdata <= 8'h00;
            out1_d_r <= 1'b1; // matches idle high output, so no false edge
        end else begin
            out1_d_r <= out_w[1];
            if (io_rd_en) begin
                io_rdata <= rd_mux_w;
            end
        end
    end

    // board outputs straight from the counter output flops
    assign tick_out      = out_w[0]; // see RULE_03
    assign conv_trig_out = out_w[2]; // see RULE_05

endmodule

// ---- tit_defines.svh ----
`ifndef TIT_DEFINES_SVH
`define TIT_DEFINES_SVH

// byte offsets on the i/o port
`define TIT_OFF_GATE_CTRL 5'h10
`define TIT_OFF_CNT0      5'h14
`define TIT_OFF_CNT1      5'h15
`define TIT_OFF_CNT2      5'h16
`define TIT_OFF_CTRL_WORD 5'h17

// gate control register field and reset value
`define TIT_GATE_BIT      1
`define TIT_GATE_OFF_RST  1'b0

// control word fields
`define TIT_CW_SEL_MSB    7
`define TIT_CW_SEL_LSB    6
`define TIT_CW_ORD_MSB    5
`define TIT_CW_ORD_LSB    4
`define TIT_CW_MODE_MSB   3
`define TIT_CW_MODE_LSB   1
`define TIT_CW_BCD_BIT    0
`define TIT_CW_SEL_RB     2'h3
`define TIT_RB_CNT_N_BIT  5
`define TIT_RB_STA_N_BIT  4
`define TIT_RB_PICK_LSB   1

// clock rates in MHz: system clock, counter 0 input, chained pair input
`define TIT_CLK_MHZ       8'h7D
`define TIT_F0_MHZ        8'h0A
`define TIT_F12_MHZ       8'h02

`endif

// ---- tit_pkg.sv ----
package tit_pkg;

    // byte transfer order programmed per counter
    typedef enum logic [1:0] {
        TIT_ORD_LATCH = 2'h0,
        TIT_ORD_LSB   = 2'h1,
        TIT_ORD_MSB   = 2'h2,
        TIT_ORD_BOTH  = 2'h3
    } tit_order_e;

    // effective counting mode after folding the don't-care bit
    typedef enum logic [2:0] {
        TIT_MODE_0 = 3'h0,
        TIT_MODE_1 = 3'h1,
        TIT_MODE_2 = 3'h2,
        TIT_MODE_3 = 3'h3,
        TIT_MODE_4 = 3'h4,
        TIT_MODE_5 = 3'h5
    } tit_mode_e;

endpackage

// ---- tit_monitor.sv ----
`timescale 1ns/1ps
module tit_monitor (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // byte i/o port
    input wire logic [4:0] io_addr,
    input wire logic       io_wr_en,
    input wire logic       io_rd_en,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // board outputs
    input wire logic       tick_out,
    input wire logic       conv_trig_out
);
    logic       gate_r;
    logic [7:0] held_r;
    logic [2:0] age_r;
    logic       pend_r;
    logic       cap_r;

    // decodes of the strobes the helpers care about
    wire gw  = io_wr_en && io_addr == 5'h10;
    wire cw  = io_wr_en && io_addr == 5'h17;
    wire rb0 = cw && io_wdata[7:6] == 2'h3 && !io_wdata[4] && io_wdata[1] && !io_wdata[0];
    wire pg0 = cw && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != 2'h0;
    wire rd0 = io_rd_en && io_addr == 5'h14;

    // gate shadow, gated run length, cycles since a write, pending status of counter 0
    // held_r restarts on every write: programming may move an output while gated
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_r <= 1'b0;
            held_r <= 8'h00;
            age_r  <= 3'h0;
            pend_r <= 1'b0;
            cap_r  <= 1'b0;
        end else begin
            if (gw) gate_r <= io_wdata[1];
            held_r <= (!gate_r || io_wr_en) ? 8'h00 : held_r + {7'h00, held_r != 8'hFF};
            age_r  <= io_wr_en ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
            if (rb0 && !pend_r) cap_r <= tick_out;
            pend_r <= rb0 || (pend_r && !rd0 && !pg0);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // outputs only move at counter steps, which lie many clocks apart, or just after a write
    sequence s_settle(x);
        ($stable(x) || age_r < 3'h6) [*8];
    endsequence
    sequence s_status_read;
        pend_r && rd0;
    endsequence

    AST_UNMAPPED: assert property (
        io_rd_en && !(io_addr inside {5'h10, 5'h14, 5'h15, 5'h16}) |=> io_rdata == 8'h00)
        else $error("unmapped read did not return zero");
    AST_RD_STANDS: assert property (!io_rd_en |=> $stable(io_rdata))
        else $error("read data moved without a read");
    AST_GATE_READ: assert property (
        io_rd_en && gw == 1'b0 && io_addr == 5'h10 |=> io_rdata == {6'h00, $past(gate_r), 1'b0})
        else $error("gate register read wrong");
    AST_GATE_HOLD: assert property (held_r >= 8'hC8 |-> $stable(conv_trig_out))
        else $error("trigger moved while gated");
    AST_TICK_STEP: assert property ($changed(tick_out) |=> s_settle(tick_out))
        else $error("tick output moved faster than its clock");
    AST_CONV_STEP: assert property ($changed(conv_trig_out) |=> s_settle(conv_trig_out))
        else $error("trigger moved faster than its clock");
    AST_RST_VAL: assert property (
        $rose(rst_b) |-> tick_out && conv_trig_out && io_rdata == 8'h00)
        else $error("outputs wrong after reset");
    AST_STATUS_OUT: assert property (s_status_read |=> io_rdata[7] == cap_r)
        else $error("status output bit wrong");
endmodule

bind tit_top tit_monitor u_mon (
    .clk          (clk),
    .rst_b        (rst_b),
    .io_addr      (io_addr),
    .io_wr_en     (io_wr_en),
    .io_rd_en     (io_rd_en),
    .io_wdata     (io_wdata),
    .io_rdata     (io_rdata),
    .tick_out     (tick_out),
    .conv_trig_out(conv_trig_out)
);

// ---- tit_host.sv ----
`timescale 1ns/1ps
module tit_host (
    // clock
    input  wire logic       clk,
    // byte port toward the timer
    output logic      [4:0] io_addr,
    output logic            io_wr_en,
    output logic            io_rd_en,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    // idle bus parks address and data away from the last value
    initial begin
        io_addr  = 5'h1F;
        io_wr_en = 1'b0;
        io_rd_en = 1'b0;
        io_wdata = 8'h00;
    end

    // one write strobe, taken at the following edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr_en <= 1'b1;
        @(posedge clk);
        io_wr_en <= 1'b0;
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask

    // one read strobe; data is settled just after the taking edge
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_rd_en <= 1'b1;
        @(posedge clk);
        io_rd_en <= 1'b0;
        io_addr  <= ~a;
        #1;
        d = io_rdata;
    endtask

    // two-byte transfers always go whole, low byte first, or the toggle slips
    task automatic wr16(input logic [4:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask
    task automatic rd16(input logic [4:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a, v[15:8]);
    endtask
endmodule

// ---- triple_interval_timer_test.sv ----
`timescale 1ns/1ps
module triple_interval_timer_test;
    logic        clk;
    logic        rst_b;
    wire  [4:0]  io_addr;
    wire         io_wr_en, io_rd_en, tick_out, conv_trig_out;
    wire  [7:0]  io_wdata, io_rdata;
    int          mismatches, comparisons, g, n;
    logic [7:0]  b;
    logic [15:0] v, w;

    tit_top dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr_en(io_wr_en),
        .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .tick_out(tick_out), .conv_trig_out(conv_trig_out));
    tit_host host (.clk(clk), .io_addr(io_addr), .io_wr_en(io_wr_en), .io_rd_en(io_rd_en),
        .io_wdata(io_wdata), .io_rdata(io_rdata));

    // 125 MHz system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // range compare; an unknown value never lands inside
    task automatic chk_rng(string nm, int lo, int hi, logic [31:0] s);
        comparisons++;
        if ((s >= lo && s <= hi) !== 1'b1) begin
            mismatches++;
            $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, s);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    function automatic logic sig(bit sel);
        return sel ? conv_trig_out : tick_out;
    endfunction
    // clocks from one falling edge to the next, bounded
    task automatic gap(input bit sel, output int t);
        logic p;
        for (int k = 0; k < 2; k++) begin
            t = 0;
            do begin
                p = sig(sel);
                @(posedge clk);
                #1;
                t++;
            end while (!(p === 1'b1 && sig(sel) === 1'b0) && t < 3000);
        end
    endtask

    task automatic t_reset;
        chk8("tick", 8'h01, {7'h00, tick_out});
        chk8("trig", 8'h01, {7'h00, conv_trig_out});
        host.rd(5'h10, b);
        chk8("gate", 8'h00, b);
        host.rd(5'h17, b);
        chk8("control read", 8'h00, b);
        host.rd(5'h1F, b);
        chk8("unmapped", 8'h00, b);
        host.wr(5'h10, 8'hFF);
        host.rd(5'h10, b);
        chk8("gate set", 8'h02, b);
    endtask

    // every mode code on counter 2, status read back; bit 3 is masked out of the compare for x1x
    task automatic t_modes;
        logic [1:0] o;
        logic [7:0] m;
        for (int c = 0; c < 8; c++) begin
            o = 2'(c % 3 + 1);
            m = c[1] ? 8'h77 : 8'h7F;
            host.wr(5'h17, {2'h2, o, 3'(c), ~c[0]});
            host.wr(5'h17, 8'hE8);
            host.rd(5'h16, b);
            chk8("mode status", {2'h1, o, 3'(c), ~c[0]} & m, b & m);
        end
    endtask

    task automatic t_div;
        host.wr(5'h17, 8'h34);
        host.wr16(5'h14, 16'h0005);
        gap(1'b0, g);
        chk_rng("tick period", 62, 63, g);
        n = 0;
        while (tick_out === 1'b0 && n < 99) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_rng("tick low", 12, 13, n);
    endtask

    task automatic t_latch;
        host.wr(5'h17, 8'h30);
        host.wr16(5'h14, 16'h1234);
        repeat (20) @(posedge clk);
        host.wr(5'h17, 8'h00);
        repeat (300) @(posedge clk);
        host.wr(5'h17, 8'h00);
        host.rd16(5'h14, v);
        chk_rng("held count", 'h1230, 'h1234, v);
        chk8("tick counting", 8'h00, {7'h00, tick_out});
        host.wr(5'h17, 8'hC2);
        host.rd(5'h14, b);
        chk8("status", 8'h30, b);
        host.rd16(5'h14, w);
        chk_rng("readback count", v - 32, v - 20, w);
        host.wr16(5'h14, 16'h0003);
        repeat (80) @(posedge clk);
        chk8("tick at zero", 8'h01, {7'h00, tick_out});
    endtask

    task automatic t_cascade;
        host.wr(5'h17, 8'hE4);
        host.rd(5'h15, b);
        chk8("idle status", 8'hD0, b);
        host.wr(5'h17, 8'h74);
        host.wr16(5'h15, 16'h0002);
        host.wr(5'h17, 8'hB4);
        host.wr16(5'h16, 16'h0002);
        host.wr(5'h10, 8'h00);
        gap(1'b1, g);
        chk_rng("trigger period", 249, 251, g);
        host.wr(5'h10, 8'h02);
        repeat (50) @(posedge clk);
        b[0] = conv_trig_out;
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (conv_trig_out !== b[0]) n++;
        end
        chk_rng("gated moves", 0, 0, n);
    endtask

    // watchdog: the whole run needs a few thousand clocks
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up;
    end

    initial begin
        rst_b = 1'b0;
        mismatches = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        t_reset;
        t_modes;
        t_div;
        t_latch;
        t_cascade;
        wrap_up;
    end
endmodule
